// ===== logic/hbsc_host_port.v
// host register port, service request outputs and acknowledge daisy chain
`timescale 1ns/1ps
`include "hbsc_regs.vh"
// Function
// R1 - external reset held at least ten clocks
// R2 - reset sampled synchronously to system clock
// R3 - init registers, disable channels, then load revision
// R4 - internal timing runs at half system clock
// R5 - cycle starts on select and strobe low
// R6 - write captured under strobe, read driven
// R7 - direction high reads, low writes
// R8 - acknowledge only after internal work finishes
// R9 - host ends cycle only after acknowledge
// R10 - seven address bits select the register
// R11 - eight bit bus driven only on reads
// R12 - acknowledge and requests are open drain
// R13 - receive request while any receiver needs service
// R14 - transmit request while any transmitter needs service
// R15 - modem request on enabled line change
// R16 - host acknowledges with matching type input
// R17 - acknowledge cycle returns matching vector
// R18 - acknowledge cycle needs grant, strobe, acknowledge
// R19 - pass chain low when no matching request
// R20 - pass output wires to next grant input
// R21 - release acknowledge and bus on strobe high
module hbsc_host_port #(
	parameter ADDR_W = `HBSC_ADDR_W,
	parameter DATA_W = `HBSC_DATA_W,
	parameter ACCESS_TICKS = `HBSC_ACCESS_TICKS,
	parameter INIT_TICKS = `HBSC_INIT_TICKS
) (
	input wire clk_sys,
	input wire reset,
	input wire clkEn,
	input wire chipSelectN,
	input wire dataStrobeN,
	input wire readWriteN,
	input wire [ADDR_W-1:0] hostAddr,
	input wire [DATA_W-1:0] hostDataBusIn,
	output wire [DATA_W-1:0] hostDataBusOut,
	output wire hostDataBusOe,
	output wire transferAckNOut,
	output wire transferAckNOe,
	output wire rxServiceRequestNOut,
	output wire rxServiceRequestNOe,
	output wire txServiceRequestNOut,
	output wire txServiceRequestNOe,
	output wire modemServiceRequestNOut,
	output wire modemServiceRequestNOe,
	input wire rxServiceAckN,
	input wire txServiceAckN,
	input wire modemServiceAckN,
	input wire chainGrantInN,
	output wire chainPassOutN,
	input wire rxNeedService,
	input wire txNeedService,
	input wire modemLineChange,
	input wire modemReportEnable,
	input wire [DATA_W-1:0] rxVector,
	input wire [DATA_W-1:0] txVector,
	input wire [DATA_W-1:0] modemVector,
	output wire [ADDR_W-1:0] regAddr,
	output wire [DATA_W-1:0] regWrData,
	output wire regWrEn,
	output wire regRdEn,
	input wire [DATA_W-1:0] regRdData,
	output wire [1:0] svcAckType,
	output wire svcAckTaken,
	output wire initBusy,
	output wire clearRegs,
	output wire disableChannels,
	output wire revisionLoad,
	output wire [DATA_W-1:0] firmwareRevision
);
	// one-hot cycle states
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_ACCESS = 5'h02;
	localparam [4:0] ST_VECTOR = 5'h04;
	localparam [4:0] ST_ACK = 5'h08;
	localparam [4:0] ST_PASS = 5'h10;

	// ==========================================================
	// helper functions

	// acknowledge type from the three inputs, receive first
	function [1:0] svcTypeOf;
		input rxAck;
		input txAck;
		input mdAck;
		begin
			if (rxAck) begin
				svcTypeOf = `HBSC_SVC_RX;
			end else if (txAck) begin
				svcTypeOf = `HBSC_SVC_TX;
			end else if (mdAck) begin
				svcTypeOf = `HBSC_SVC_MODEM;
			end else begin
				svcTypeOf = `HBSC_SVC_NONE;
			end
		end
	endfunction

	// is a request of this type pending
	function pendingOf;
		input [1:0] kind;
		input rxReq;
		input txReq;
		input mdReq;
		begin
			case (kind)
				`HBSC_SVC_RX: pendingOf = rxReq;
				`HBSC_SVC_TX: pendingOf = txReq;
				`HBSC_SVC_MODEM: pendingOf = mdReq;
				default: pendingOf = 1'b0;
			endcase
		end
	endfunction

	// ==========================================================
	// state
	reg [4:0] state_r;
	reg [4:0] state_nxt;
	reg tick_r;
	reg [`HBSC_CNT_W-1:0] accessCnt_r;
	reg [`HBSC_CNT_W-1:0] accessCnt_nxt;
	reg isRead_r;
	reg isRead_nxt;
	reg [ADDR_W-1:0] addr_r;
	reg [ADDR_W-1:0] addr_nxt;
	reg [DATA_W-1:0] wrData_r;
	reg [DATA_W-1:0] wrData_nxt;
	reg [DATA_W-1:0] dataOut_r;
	reg [DATA_W-1:0] dataOut_nxt;
	reg busOe_r;
	reg busOe_nxt;
	reg ackOe_r;
	reg ackOe_nxt;
	reg passLow_r;
	reg passLow_nxt;
	reg wrEn_r;
	reg wrEn_nxt;
	reg rdEn_r;
	reg rdEn_nxt;
	reg [1:0] svcType_r;
	reg [1:0] svcType_nxt;
	reg svcTaken_r;
	reg svcTaken_nxt;
	reg rxReq_r;
	reg txReq_r;
	reg mdReq_r;
	wire seqBusy;

	// ==========================================================
	// start-up sequencer
	hbsc_init_seq #(
		.INIT_TICKS(INIT_TICKS),
		.FW_REVISION(`HBSC_FW_REVISION)
	) u_init (
		.clk_sys(clk_sys),
		.reset(reset),
		.clkEn(clkEn),
		.tick(tick_r),
		.initBusy_r(seqBusy),
		.clearRegs_r(clearRegs),
		.disableChannels_r(disableChannels),
		.revisionLoad_r(revisionLoad),
		.firmwareRevision_r(firmwareRevision)
	);
	assign initBusy = seqBusy;

	// ==========================================================
	// half-rate timing tick
	// idle, access and vector steps wait for this and run at clk/2; ack and pass release do not
	always @(posedge clk_sys) begin
		if (reset) begin // [R2]
			tick_r <= 1'b0;
		end else if (clkEn) begin
			tick_r <= ~tick_r; // [R4]
		end
	end

	// ==========================================================
	// decoded host conditions
	wire hostSelect = ~chipSelectN & ~dataStrobeN; // [R5]
	wire [1:0] ackKind = svcTypeOf(~rxServiceAckN, ~txServiceAckN, ~modemServiceAckN);
	wire ackValid = (ackKind != `HBSC_SVC_NONE);
	wire ackCycle = ~chainGrantInN & ~dataStrobeN & ackValid; // [R18]
	wire ackPending = pendingOf(ackKind, rxReq_r, txReq_r, mdReq_r);

	// ==========================================================
	// cycle sequencer, next-state logic
	// acknowledge cycles win over plain register cycles: the host
	// holds select high during them, but a stray select must not split one
	always @* begin
		state_nxt = state_r;
		accessCnt_nxt = accessCnt_r;
		isRead_nxt = isRead_r;
		addr_nxt = addr_r;
		wrData_nxt = wrData_r;
		dataOut_nxt = dataOut_r;
		busOe_nxt = busOe_r;
		ackOe_nxt = ackOe_r;
		passLow_nxt = passLow_r;
		wrEn_nxt = 1'b0;
		rdEn_nxt = 1'b0;
		svcType_nxt = svcType_r;
		svcTaken_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				busOe_nxt = 1'b0;
				ackOe_nxt = 1'b0;
				passLow_nxt = 1'b0;
				if (tick_r && !seqBusy) begin
					if (ackCycle) begin
						svcType_nxt = ackKind;
						if (ackPending) begin
							state_nxt = ST_VECTOR; // [R17]
						end else begin
							passLow_nxt = 1'b1; // [R19]
							state_nxt = ST_PASS;
						end
					end else if (hostSelect) begin
						addr_nxt = hostAddr; // [R10]
						isRead_nxt = readWriteN; // [R7]
						wrData_nxt = hostDataBusIn; // [R6]
						wrEn_nxt = ~readWriteN; // [R6]
						rdEn_nxt = readWriteN;
						accessCnt_nxt = {`HBSC_CNT_W{1'b0}};
						state_nxt = ST_ACCESS;
					end
				end
			end
			ST_ACCESS: begin
				// internal work takes a fixed number of ticks
				if (tick_r) begin
					if (accessCnt_r == ACCESS_TICKS[`HBSC_CNT_W-1:0] - 1'b1) begin
						if (isRead_r) begin
							dataOut_nxt = regRdData;
							busOe_nxt = 1'b1; // [R11]
						end
						ackOe_nxt = 1'b1; // [R8]
						state_nxt = ST_ACK;
					end else begin
						accessCnt_nxt = accessCnt_r + 1'b1;
					end
				end
			end
			ST_VECTOR: begin
				// vector of the acknowledged type onto the bus
				if (tick_r) begin
					case (svcType_r)
						`HBSC_SVC_RX: dataOut_nxt = rxVector; // [R17]
						`HBSC_SVC_TX: dataOut_nxt = txVector; // [R17]
						default: dataOut_nxt = modemVector; // [R17]
					endcase
					isRead_nxt = 1'b1;
					busOe_nxt = 1'b1; // [R11]
					ackOe_nxt = 1'b1; // [R8]
					svcTaken_nxt = 1'b1;
					state_nxt = ST_ACK;
				end
			end
			ST_ACK: begin
				// host may end only now; strobe rise releases all
				if (dataStrobeN) begin
					busOe_nxt = 1'b0; // [R21]
					ackOe_nxt = 1'b0; // [R21]
					state_nxt = ST_IDLE;
				end
			end
			ST_PASS: begin
				// chain pass held until the acknowledge cycle ends
				if (dataStrobeN || chainGrantInN || !ackValid) begin
					passLow_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				busOe_nxt = 1'b0;
				ackOe_nxt = 1'b0;
				passLow_nxt = 1'b0;
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// cycle sequencer registers
	always @(posedge clk_sys) begin
		if (reset) begin // [R2]
			state_r <= ST_IDLE;
			accessCnt_r <= {`HBSC_CNT_W{1'b0}};
			isRead_r <= 1'b0;
			addr_r <= {ADDR_W{1'b0}};
			wrData_r <= `HBSC_DATA_ZERO;
			dataOut_r <= `HBSC_DATA_ZERO;
			busOe_r <= 1'b0;
			ackOe_r <= 1'b0;
			passLow_r <= 1'b0;
			wrEn_r <= 1'b0;
			rdEn_r <= 1'b0;
			svcType_r <= `HBSC_SVC_NONE;
			svcTaken_r <= 1'b0;
		end else if (clkEn) begin
			state_r <= state_nxt;
			accessCnt_r <= accessCnt_nxt;
			isRead_r <= isRead_nxt;
			addr_r <= addr_nxt;
			wrData_r <= wrData_nxt;
			dataOut_r <= dataOut_nxt;
			busOe_r <= busOe_nxt;
			ackOe_r <= ackOe_nxt;
			passLow_r <= passLow_nxt;
			wrEn_r <= wrEn_nxt;
			rdEn_r <= rdEn_nxt;
			svcType_r <= svcType_nxt;
			svcTaken_r <= svcTaken_nxt;
		end
	end

	// ==========================================================
	// service request flops
	// held off while start-up runs, the channels are not yet valid
	always @(posedge clk_sys) begin
		if (reset) begin // [R2]
			rxReq_r <= 1'b0;
			txReq_r <= 1'b0;
			mdReq_r <= 1'b0;
		end else if (clkEn) begin
			rxReq_r <= rxNeedService & ~seqBusy; // [R13]
			txReq_r <= txNeedService & ~seqBusy; // [R14]
			mdReq_r <= modemLineChange & modemReportEnable & ~seqBusy; // [R15]
		end
	end

	// ==========================================================
	// pin drive: open-drain lines only ever pull low
	assign transferAckNOut = 1'b0; // [R12]
	assign transferAckNOe = ackOe_r; // [R12]
	assign rxServiceRequestNOut = 1'b0;
	assign rxServiceRequestNOe = rxReq_r; // [R12]
	assign txServiceRequestNOut = 1'b0;
	assign txServiceRequestNOe = txReq_r; // [R12]
	assign modemServiceRequestNOut = 1'b0;
	assign modemServiceRequestNOe = mdReq_r; // [R12]
	assign hostDataBusOut = dataOut_r;
	assign hostDataBusOe = busOe_r; // [R11]
	assign chainPassOutN = ~passLow_r; // [R19]

	// ==========================================================
	// core side register access
	assign regAddr = addr_r;
	assign regWrData = wrData_r;
	assign regWrEn = wrEn_r;
	assign regRdEn = rdEn_r;
	assign svcAckType = svcType_r;
	assign svcAckTaken = svcTaken_r;
endmodule

// ===== logic/hbsc_regs.vh
// constants of the host bus and service chain port
`ifndef HBSC_REGS_VH
`define HBSC_REGS_VH
`define HBSC_ADDR_W 7
`define HBSC_DATA_W 8
`define HBSC_RESET_MIN_CYCLES 10
`define HBSC_ACCESS_TICKS 2
`define HBSC_INIT_TICKS 16
`define HBSC_CNT_W 8
`define HBSC_FW_REVISION 8'h4a
`define HBSC_DATA_ZERO 8'h00
`define HBSC_SVC_NONE 2'h0
`define HBSC_SVC_RX 2'h1
`define HBSC_SVC_TX 2'h2
`define HBSC_SVC_MODEM 2'h3
`endif

// ===== logic/hbsc_init_seq.v
// start-up sequencer: register clear, channel disable, revision load
`timescale 1ns/1ps
`include "hbsc_regs.vh"
module hbsc_init_seq #(
	parameter INIT_TICKS = `HBSC_INIT_TICKS,
	parameter [`HBSC_DATA_W-1:0] FW_REVISION = `HBSC_FW_REVISION
) (
	input wire clk_sys,
	input wire reset,
	input wire clkEn,
	input wire tick,
	output reg initBusy_r,
	output reg clearRegs_r,
	output reg disableChannels_r,
	output reg revisionLoad_r,
	output reg [`HBSC_DATA_W-1:0] firmwareRevision_r
);
	reg [`HBSC_CNT_W-1:0] initCnt_r;

	// ==========================================================
	// sequence after reset release
	// registers are cleared first, channels disabled, revision last
	always @(posedge clk_sys) begin
		if (reset) begin
			initBusy_r <= 1'b1;
			clearRegs_r <= 1'b1;
			disableChannels_r <= 1'b0;
			revisionLoad_r <= 1'b0;
			firmwareRevision_r <= `HBSC_DATA_ZERO;
			initCnt_r <= {`HBSC_CNT_W{1'b0}};
		end else if (clkEn) begin
			disableChannels_r <= 1'b0;
			revisionLoad_r <= 1'b0;
			if (initBusy_r && tick) begin
				if (initCnt_r == INIT_TICKS[`HBSC_CNT_W-1:0] - 1'b1) begin
					// revision appears only once the rest is done [R3]
					initBusy_r <= 1'b0;
					revisionLoad_r <= 1'b1;
					firmwareRevision_r <= FW_REVISION;
				end else begin
					if (initCnt_r == {`HBSC_CNT_W{1'b0}}) begin
						disableChannels_r <= 1'b1; // [R3]
					end
					if (initCnt_r == INIT_TICKS[`HBSC_CNT_W-1:0] - 2'd2) begin
						clearRegs_r <= 1'b0; // [R3]
					end
					initCnt_r <= initCnt_r + 1'b1;
				end
			end
		end
	end
endmodule

// ===== bench/hbsc_host_port_checker.sv
// checker of the host port pins, request outputs and daisy chain
`timescale 1ns/1ps
module hbsc_host_port_checker #(
	parameter ADDR_W = 7,
	parameter DATA_W = 8
) (
	input wire clk_sys,
	input wire reset,
	input wire chipSelectN,
	input wire dataStrobeN,
	input wire readWriteN,
	input wire [ADDR_W-1:0] hostAddr,
	input wire [DATA_W-1:0] hostDataBusIn,
	input wire hostDataBusOe,
	input wire transferAckNOut,
	input wire transferAckNOe,
	input wire rxServiceRequestNOe,
	input wire txServiceRequestNOe,
	input wire modemServiceRequestNOe,
	input wire chainGrantInN,
	input wire chainPassOutN,
	input wire rxNeedService,
	input wire txNeedService,
	input wire modemLineChange,
	input wire modemReportEnable,
	input wire [ADDR_W-1:0] regAddr,
	input wire [DATA_W-1:0] regWrData,
	input wire regWrEn,
	input wire regRdEn,
	input wire initBusy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ==========================================
	// sequences
	sequence s_wrTake;
		!initBusy && !chipSelectN && !dataStrobeN && !readWriteN ##1 regWrEn;
	endsequence
	// ==========================================
	// properties
	chk_ack_latency: assert property (s_wrTake |-> ##[3:6] transferAckNOe)
		else $error("write acknowledge late");
	chk_ack_release: assert property (dataStrobeN && $past(dataStrobeN) |-> !transferAckNOe && !hostDataBusOe)
		else $error("ack or bus held after strobe high");
	chk_busy_quiet: assert property (initBusy |-> !transferAckNOe && !regWrEn && !regRdEn)
		else $error("cycle taken during start-up");
	chk_wr_cause: assert property (regWrEn |-> $past(!chipSelectN && !dataStrobeN && !readWriteN))
		else $error("write without select, strobe and write level");
	chk_rd_cause: assert property (regRdEn |-> $past(!chipSelectN && !dataStrobeN && readWriteN))
		else $error("read without select, strobe and read level");
	chk_addr_latch: assert property (regWrEn |-> regAddr == $past(hostAddr) && regWrData == $past(hostDataBusIn))
		else $error("address or write data not latched");
	chk_rx_request: assert property (!initBusy && !$past(initBusy) |-> rxServiceRequestNOe == $past(rxNeedService))
		else $error("receive request wrong");
	chk_tx_request: assert property (!initBusy && !$past(initBusy) |-> txServiceRequestNOe == $past(txNeedService))
		else $error("transmit request wrong");
	chk_modem_request: assert property (!initBusy && !$past(initBusy) |->
		modemServiceRequestNOe == $past(modemLineChange && modemReportEnable))
		else $error("modem request wrong");
	chk_pass_cause: assert property (!chainPassOutN |-> $past(!chainGrantInN && !dataStrobeN))
		else $error("pass without grant and strobe");
	chk_ack_drain: assert property (transferAckNOut == 1'b0)
		else $error("acknowledge drives high");
endmodule
bind hbsc_host_port hbsc_host_port_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clk_sys, .reset,
	.chipSelectN, .dataStrobeN, .readWriteN, .hostAddr, .hostDataBusIn, .hostDataBusOe, .transferAckNOut,
	.transferAckNOe, .rxServiceRequestNOe, .txServiceRequestNOe, .modemServiceRequestNOe, .chainGrantInN,
	.chainPassOutN, .rxNeedService, .txNeedService, .modemLineChange, .modemReportEnable, .regAddr,
	.regWrData, .regWrEn, .regRdEn, .initBusy);

// ===== bench/hbsc_host_model.sv
// host processor model: register cycles and service acknowledge cycles
`timescale 1ns/1ps
module hbsc_host_model (
	input wire clk_sys,
	input wire ackWireN,
	input wire passN,
	input wire [7:0] busIn,
	output reg chipSelectN,
	output reg dataStrobeN,
	output reg readWriteN,
	output reg [6:0] hostAddr,
	output reg [7:0] hostDrv,
	output reg hostOe,
	output reg [2:0] svcAckN,
	output reg chainGrantInN
);
	// idle bus from time zero
	initial begin
		chipSelectN = 1'b1;
		dataStrobeN = 1'b1;
		readWriteN = 1'b1;
		hostAddr = 7'h00;
		hostDrv = 8'h00;
		hostOe = 1'b0;
		svcAckN = 3'b111;
		chainGrantInN = 1'b1;
	end
	// kind 0 register cycle, 1..3 acknowledge; res 0 none, 1 acked, 2 passed on
	task cyc(input [1:0] kind, input rw, input g, input [6:0] a, input [7:0] d, output [7:0] rd, output [1:0] res);
		integer n;
		begin
			@(negedge clk_sys);
			chipSelectN = (kind != 2'd0);
			readWriteN = rw | (kind != 2'd0);
			hostAddr = a;
			hostDrv = d;
			hostOe = !readWriteN;
			chainGrantInN = g;
			svcAckN = (kind == 2'd0) ? 3'b111 : ~(3'b001 << (kind - 2'd1));
			dataStrobeN = 1'b0;
			res = 2'd0;
			// strobe held until answer seen, bounded wait
			for (n = 0; n < 40 && res == 2'd0; n = n + 1) begin
				@(negedge clk_sys);
				if (!ackWireN) res = 2'd1;
				else if (!passN) res = 2'd2;
			end
			rd = busIn;
			dataStrobeN = 1'b1;
			chipSelectN = 1'b1;
			hostOe = 1'b0;
			svcAckN = 3'b111;
			chainGrantInN = 1'b1;
			@(negedge clk_sys);
		end
	endtask
endmodule

// ===== bench/hbsc_host_port_test.sv
// testbench of the host port with host model and bench register file
`timescale 1ns/1ps
`include "hbsc_regs.vh"
module hbsc_host_port_test;
	reg clk_sys = 1'b0;
	reg reset = 1'b1;
	reg rxNeedService = 1'b0, txNeedService = 1'b0, modemLineChange = 1'b0, modemReportEnable = 1'b0;
	reg [7:0] rxVector = 8'h00, txVector = 8'h00, modemVector = 8'h00, busLast = 8'h00;
	reg [7:0] regFile [0:127];
	reg [7:0] expMem [0:127];
	reg [6:0] addrs [0:7];
	reg [7:0] rd, vec;
	reg [1:0] res;
	integer seed = 32'h088167fc, miscompares = 0, total_checks = 0, i, k;
	integer disCnt = 0, revCnt = 0, rdCnt = 0, takeCnt = 0;
	reg clkEn = 1'b1;
	wire chipSelectN, dataStrobeN, readWriteN, hostOe, chainGrantInN, chainPassOutN, initBusy, regWrEn;
	wire transferAckNOut, transferAckNOe, rxServiceRequestNOe, txServiceRequestNOe, modemServiceRequestNOe;
	wire hostDataBusOe;
	wire clearRegs, disableChannels, revisionLoad, regRdEn, svcAckTaken;
	wire [2:0] svcAckN;
	wire [1:0] svcAckType;
	wire [6:0] hostAddr, regAddr;
	wire [7:0] hostDrv, hostDataBusOut, regWrData, firmwareRevision;
	// ==========================================
	// clock, wires and bench register file
	always #5 clk_sys = ~clk_sys;
	wire ackWireN = transferAckNOe ? transferAckNOut : 1'b1;
	wire [7:0] bus = hostDataBusOe ? hostDataBusOut : hostOe ? hostDrv : busLast;
	wire [7:0] regRdData = regFile[regAddr];
	// a floating bus shows a changing pattern, never the last value
	always @(posedge clk_sys) busLast <= ~bus;
	always @(posedge clk_sys) if (regWrEn) regFile[regAddr] <= regWrData;
	// pulse counters for the one-cycle side outputs, a stuck pulse shows as a surplus
	always @(posedge clk_sys) begin
		disCnt <= disCnt + disableChannels;
		revCnt <= revCnt + revisionLoad;
		rdCnt <= rdCnt + regRdEn;
		takeCnt <= takeCnt + svcAckTaken;
	end
	hbsc_host_model host (.clk_sys, .ackWireN, .passN(chainPassOutN), .busIn(bus), .chipSelectN, .dataStrobeN,
		.readWriteN, .hostAddr, .hostDrv, .hostOe, .svcAckN, .chainGrantInN);
	hbsc_host_port dut (.clk_sys, .reset, .clkEn, .chipSelectN, .dataStrobeN, .readWriteN, .hostAddr,
		.hostDataBusIn(bus), .hostDataBusOut, .hostDataBusOe, .transferAckNOut, .transferAckNOe,
		.rxServiceRequestNOut(), .rxServiceRequestNOe, .txServiceRequestNOut(), .txServiceRequestNOe,
		.modemServiceRequestNOut(), .modemServiceRequestNOe, .rxServiceAckN(svcAckN[0]),
		.txServiceAckN(svcAckN[1]), .modemServiceAckN(svcAckN[2]), .chainGrantInN, .chainPassOutN,
		.rxNeedService, .txNeedService, .modemLineChange, .modemReportEnable, .rxVector, .txVector, .modemVector,
		.regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .svcAckType, .svcAckTaken, .initBusy,
		.clearRegs, .disableChannels, .revisionLoad, .firmwareRevision);
	// ==========================================
	// comparison, cycle wrapper and verdict
	task check(input string name, input [7:0] seen, input [7:0] expv);
		begin
			total_checks = total_checks + 1;
			if (seen !== expv) begin
				miscompares = miscompares + 1;
				$display("[ERR] %0s expected %h seen %h", name, expv, seen);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, miscompares);
			if (miscompares == 0 && total_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// a missing answer where one is due ends the run
	task run(input [1:0] kind, input rw, input g, input [6:0] a, input [7:0] d, input [1:0] want);
		begin
			host.cyc(kind, rw, g, a, d, rd, res);
			check("result", {6'h00, res}, {6'h00, want});
			if (res == 2'd0 && want != 2'd0) stop_test;
		end
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (`HBSC_RESET_MIN_CYCLES) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		check("initBusy", {7'h00, initBusy}, 8'h01);
		check("revision", firmwareRevision, 8'h00);
		check("clearRegs", {7'h00, clearRegs}, 8'h01);
		for (i = 0; i < 200 && initBusy !== 1'b0; i = i + 1) @(negedge clk_sys);
		// a start-up that never ends is counted before the run stops
		check("initBusy", {7'h00, initBusy}, 8'h00);
		if (initBusy !== 1'b0) stop_test;
		check("revision", firmwareRevision, `HBSC_FW_REVISION);
		// the load pulse lands with busy falling, let the counter see it
		@(negedge clk_sys);
		check("clearRegs", {7'h00, clearRegs}, 8'h00);
		check("disable pulses", disCnt[7:0], 8'h01);
		check("revision pulses", revCnt[7:0], 8'h01);
		$display("test start-up done");
		// random writes back to back, then read back
		for (i = 0; i < 8; i = i + 1) begin
			addrs[i] = 7'($random(seed));
			vec = 8'($random(seed));
			expMem[addrs[i]] = vec;
			run(2'd0, 1'b0, 1'b1, addrs[i], vec, 2'd1);
		end
		for (i = 0; i < 8; i = i + 1) begin
			run(2'd0, 1'b1, 1'b1, addrs[i], 8'h00, 2'd1);
			check("read data", rd, expMem[addrs[i]]);
		end
		check("read enables", rdCnt[7:0], 8'h08);
		// clock enable low freezes the port: no answer, no write, then read back
		@(negedge clk_sys);
		clkEn = 1'b0;
		run(2'd0, 1'b0, 1'b1, addrs[0], ~expMem[addrs[0]], 2'd0);
		clkEn = 1'b1;
		run(2'd0, 1'b1, 1'b1, addrs[0], 8'h00, 2'd1);
		check("frozen write", rd, expMem[addrs[0]]);
		$display("test register cycles done");
		// each request type alone: vector, pass on, no grant
		for (k = 1; k < 4; k = k + 1) begin
			@(negedge clk_sys);
			rxNeedService = (k == 1);
			txNeedService = (k == 2);
			modemLineChange = 1'b1;
			modemReportEnable = (k == 3);
			rxVector = 8'($random(seed));
			txVector = 8'($random(seed));
			modemVector = 8'($random(seed));
			vec = (k == 1) ? rxVector : (k == 2) ? txVector : modemVector;
			repeat (2) @(negedge clk_sys);
			check("requests", {5'h00, modemServiceRequestNOe, txServiceRequestNOe, rxServiceRequestNOe},
				8'h01 << (k - 1));
			run(k[1:0], 1'b1, 1'b0, 7'h00, 8'h00, 2'd1);
			check("vector", rd, vec);
			check("ack type", {6'h00, svcAckType}, k[7:0]);
			run(k[1:0] % 2'd3 + 2'd1, 1'b1, 1'b0, 7'h00, 8'h00, 2'd2);
			run(k[1:0], 1'b1, 1'b1, 7'h00, 8'h00, 2'd0);
		end
		check("vector takes", takeCnt[7:0], 8'h03);
		$display("test service chain done");
		stop_test;
	end
endmodule
